// ---- design/cgc_map.svh ----
`ifndef CGC_MAP_SVH
`define CGC_MAP_SVH
`define CGC_OFS_CLOCK_OUTPUT_SELECT    12'h010
`define CGC_OFS_KEY       12'h014
`define CGC_OFS_DIV       12'h018
`define CGC_OFS_STATUS    12'h01c
`define CGC_OFS_TRIM      12'h020
`define CGC_OFS_TRIMVAL   12'h024
`define CGC_OFS_GATESTAT  12'h028
`define CGC_OFS_SERGATE   12'h02c
`define CGC_OFS_OSCCTL    12'h030
`define CGC_OFS_IRQ_EN    12'h100
`define CGC_OFS_IRQ_STAT  12'h104
`define CGC_OFS_IRQ_CLR   12'h108
`define CGC_OFS_IRQ_SET   12'h10c
`define CGC_KEY_VALUE     32'h0000_0047
`define CGC_CORE_RESET    3'h7
`define CGC_FLASH_DIV_LO  6'h18
`define CGC_FLASH_DIV_HI  6'h2c
`define CGC_PCLK_HZ       50000000
`define CGC_XT_MIN_HZ     8000
`define CGC_XT_FAIL_MS    32
`define CGC_XT_SEC_MASK   15'h7fff
`define CGC_WARM_SHORT    11'h002
`define CGC_WARM_LONG     11'h004
`define CGC_IRQ_ALARM     3
`define CGC_IRQ_XTFAIL    2
`define CGC_IRQ_ACDONE    1
`define CGC_IRQ_ACFAIL    0
`endif

// ---- design/cgc_pkg.sv ----
`default_nettype none
package cgc_pkg;
  typedef enum logic [1:0] {TR_IDLE, TR_WARM, TR_APPLY, TR_WAIT} cgc_trim_e;

  typedef struct packed {
    logic xt;
    logic low_freq_rc_osc;
    logic ulfrc;
    logic high_freq_rc_osc;
    logic rtc_1hz;
    logic hz100;
  } cgc_ticks_s;

  typedef struct packed {
    logic alarm;
    logic autocal_done;
    logic autocal_fail;
  } cgc_events_s;

  typedef struct packed {
    logic [31:0] key;
    logic [5:0]  clock_output_select_sel;
    logic        flash_sel;
    logic [2:0]  core_sel;
    logic        warm_sel;
    logic [10:0] trim_target;
    logic [2:0]  trim_period;
    logic        trim_en;
    logic [10:0] trim_value;
    logic        uart_en;
    logic [3:0]  irq_en;
    logic [3:0]  irq_flag;
    logic        osc_req;
    logic        switch_on_failure;
    logic        rtc_low_freq_rc_osc;
    logic        xt_slow;
    logic        xt_fail;
    logic [15:0] gap_cnt;
    logic [20:0] fail_cnt;
    logic        pwr_done;
    logic [20:0] xt_cnt;
    logic [23:0] hf_cnt;
    logic [19:0] lf_cnt;
    logic [19:0] ulf_cnt;
    logic [2:0]  core_cnt;
    logic [5:0]  flash_cnt;
    logic        core_clk_en;
    logic        flash_clk_en;
    cgc_trim_e   trim_st;
    logic [10:0] sec_cnt;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        clock_output_select;
    logic [2:0]  auto_en;
    logic        irq;
  } cgc_state_s;
endpackage : cgc_pkg
`default_nettype wire

// ---- design/cgc_top.sv ----
// Register access over APB is this design's own decision.
`include "cgc_map.svh"
`default_nettype none
module cgc_top
  import cgc_pkg::*;
#(
  parameter int unsigned XT_SLOW_GAP_CYC = `CGC_PCLK_HZ / `CGC_XT_MIN_HZ,
  parameter int unsigned XT_FAIL_CYC     = `CGC_PCLK_HZ / 1000 * `CGC_XT_FAIL_MS
) (
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        cken,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // oscillator ticks and outside events
  input  wire cgc_ticks_s  ticks,
  input  wire cgc_events_s events,
  input  wire logic        xt_enabled,
  // clock controls
  output logic             clock_output_select,
  output logic             core_clk_en,
  output logic             flash_clk_en,
  output logic             serial_clock_enable,
  output logic [2:0]       src_auto_enable,
  output logic             rtc_osc_in_use,
  output logic [10:0]      trim_current_value,
  output logic             irq
);

  cgc_state_s st;
  cgc_state_s next_st;

  // counter bit n-1 of a free prescaler gives divide by 2^n
  function automatic logic div_bit(input logic [23:0] cnt, input int unsigned pow);
    div_bit = cnt[pow - 1];
  endfunction : div_bit

  // codes 0..7 give 4,16,32..1024 seconds
  function automatic logic [10:0] period_secs(input logic [2:0] code);
    period_secs = (code == 3'h0) ? 11'h004 : 11'(11'h008 << code);
  endfunction : period_secs

  logic        wr_acc;
  logic        rd_acc;
  logic        sec_tick;
  logic        known;
  logic        sel_bit;
  logic [2:0]  auto_req;
  logic [3:0]  hw_set;
  logic [31:0] rd_data;

  always_comb begin
    next_st = st;
    wr_acc = psel && penable && st.pready && pwrite;
    rd_acc = psel && penable && !st.pready;
    // one wait cycle: pready rises on the second access cycle
    next_st.pready = psel && penable && !st.pready;
    known = 1'b1;
    case (paddr)
      `CGC_OFS_CLOCK_OUTPUT_SELECT, `CGC_OFS_KEY, `CGC_OFS_DIV, `CGC_OFS_STATUS, `CGC_OFS_TRIM,
      `CGC_OFS_TRIMVAL, `CGC_OFS_GATESTAT, `CGC_OFS_SERGATE, `CGC_OFS_OSCCTL,
      `CGC_OFS_IRQ_EN, `CGC_OFS_IRQ_STAT, `CGC_OFS_IRQ_CLR, `CGC_OFS_IRQ_SET: known = 1'b1;
      default: known = 1'b0;
    endcase

    // read data
    rd_data = 32'h0000_0000;
    case (paddr)
      `CGC_OFS_CLOCK_OUTPUT_SELECT:   rd_data = {26'h0, st.clock_output_select_sel};
      `CGC_OFS_KEY:      rd_data = st.key;
      `CGC_OFS_DIV:      rd_data = {28'h0, st.flash_sel, st.core_sel};
      `CGC_OFS_STATUS:   rd_data = {30'h0, (xt_enabled && st.xt_slow) || st.osc_req,
                                    st.rtc_low_freq_rc_osc};
      `CGC_OFS_TRIM:     rd_data = {12'h0, st.warm_sel, st.trim_target, 4'h0,
                                    st.trim_period, st.trim_en};
      `CGC_OFS_TRIMVAL:  rd_data = {21'h0, st.trim_value};
      `CGC_OFS_GATESTAT: rd_data = {28'h0, st.auto_en, st.uart_en};
      `CGC_OFS_SERGATE:  rd_data = {31'h0, st.uart_en};
      `CGC_OFS_OSCCTL:   rd_data = {30'h0, st.switch_on_failure, st.osc_req};
      `CGC_OFS_IRQ_EN:   rd_data = {28'h0, st.irq_en};
      `CGC_OFS_IRQ_STAT: rd_data = {28'h0, st.irq_flag};
      default:           rd_data = 32'h0000_0000;
    endcase
    if (rd_acc) begin
      next_st.prdata  = pwrite ? 32'h0000_0000 : rd_data;
      next_st.pslverr = !known;
    end

    // register writes; clear/set are handled with the flags
    if (wr_acc) begin
      case (paddr)
        `CGC_OFS_CLOCK_OUTPUT_SELECT:  next_st.clock_output_select_sel = pwdata[5:0];
        `CGC_OFS_KEY:     next_st.key = pwdata;
        `CGC_OFS_DIV: begin
          if (st.key == `CGC_KEY_VALUE) begin
            next_st.flash_sel = pwdata[3];
            next_st.core_sel  = pwdata[2:0];
          end
        end
        `CGC_OFS_TRIM: begin
          next_st.warm_sel    = pwdata[19];
          next_st.trim_target = pwdata[18:8];
          next_st.trim_period = pwdata[3:1];
          next_st.trim_en     = pwdata[0];
        end
        `CGC_OFS_SERGATE: next_st.uart_en = pwdata[0];
        `CGC_OFS_OSCCTL: begin
          next_st.switch_on_failure     = pwdata[1];
          next_st.osc_req = pwdata[0];
        end
        `CGC_OFS_IRQ_EN:  next_st.irq_en = pwdata[3:0];
        default: ;
      endcase
    end

    // prescalers run on source ticks
    if (ticks.xt) next_st.xt_cnt = st.xt_cnt + 21'h1;
    if (ticks.high_freq_rc_osc) next_st.hf_cnt = st.hf_cnt + 24'h1;
    if (ticks.low_freq_rc_osc) next_st.lf_cnt = st.lf_cnt + 20'h1;
    if (ticks.ulfrc) next_st.ulf_cnt = st.ulf_cnt + 20'h1;
    sec_tick = ticks.xt && (st.xt_cnt[14:0] == `CGC_XT_SEC_MASK);

    // core and flash enables are single-cycle pulses on high_freq_rc_osc ticks
    next_st.core_clk_en  = 1'b0;
    next_st.flash_clk_en = 1'b0;
    if (ticks.high_freq_rc_osc) begin
      if (st.core_cnt >= st.core_sel) begin
        next_st.core_cnt    = 3'h0;
        next_st.core_clk_en = 1'b1;
      end else begin
        next_st.core_cnt = st.core_cnt + 3'h1;
      end
      if (st.flash_cnt >= (st.flash_sel ? `CGC_FLASH_DIV_HI : `CGC_FLASH_DIV_LO)) begin
        next_st.flash_cnt    = 6'h00;
        next_st.flash_clk_en = 1'b1;
      end else begin
        next_st.flash_cnt = st.flash_cnt + 6'h01;
      end
    end

    // clock output select; bits: {high_freq_rc_osc, xt, low_freq_rc_osc} auto-enable
    auto_req = 3'h0;
    case (st.clock_output_select_sel)
      6'h01: begin sel_bit = div_bit(24'(st.xt_cnt), 1); auto_req = 3'h2; end
      6'h02: begin sel_bit = div_bit(24'(st.xt_cnt), 2); auto_req = 3'h2; end
      6'h03: begin sel_bit = div_bit(24'(st.xt_cnt), 3); auto_req = 3'h2; end
      6'h04: begin sel_bit = div_bit(24'(st.xt_cnt), 4); auto_req = 3'h2; end
      6'h05: begin sel_bit = div_bit(24'(st.xt_cnt), 5); auto_req = 3'h2; end
      6'h10: sel_bit = ticks.rtc_1hz;
      6'h16: begin sel_bit = div_bit(24'(st.xt_cnt), 21); auto_req = 3'h2; end
      6'h17: begin sel_bit = ticks.xt; auto_req = 3'h2; end
      6'h18: sel_bit = ticks.hz100;
      6'h19: begin sel_bit = ticks.high_freq_rc_osc; auto_req = 3'h4; end
      6'h1a: begin sel_bit = div_bit(st.hf_cnt, 1); auto_req = 3'h4; end
      6'h1b: begin sel_bit = div_bit(st.hf_cnt, 2); auto_req = 3'h4; end
      6'h1c: begin sel_bit = div_bit(st.hf_cnt, 3); auto_req = 3'h4; end
      6'h1d: begin sel_bit = div_bit(st.hf_cnt, 5); auto_req = 3'h4; end
      6'h1e: begin sel_bit = div_bit(st.hf_cnt, 6); auto_req = 3'h4; end
      6'h1f: begin sel_bit = div_bit(st.hf_cnt, 7); auto_req = 3'h4; end
      6'h20: begin sel_bit = div_bit(st.hf_cnt, 8); auto_req = 3'h4; end
      6'h22: begin sel_bit = st.flash_clk_en; auto_req = 3'h4; end
      6'h23: begin sel_bit = div_bit(24'(st.lf_cnt), 1); auto_req = 3'h1; end
      6'h24: begin sel_bit = div_bit(24'(st.lf_cnt), 5); auto_req = 3'h1; end
      6'h25: begin sel_bit = div_bit(24'(st.lf_cnt), 9); auto_req = 3'h1; end
      6'h26: begin sel_bit = div_bit(24'(st.lf_cnt), 15); auto_req = 3'h1; end
      6'h27: begin sel_bit = div_bit(24'(st.xt_cnt), 8); auto_req = 3'h2; end
      6'h28: begin sel_bit = div_bit(24'(st.xt_cnt), 13); auto_req = 3'h2; end
      6'h29: begin sel_bit = div_bit(24'(st.xt_cnt), 16); auto_req = 3'h2; end
      6'h2a: begin sel_bit = div_bit(24'(st.ulf_cnt), 4); auto_req = 3'h1; end
      6'h2b: begin sel_bit = div_bit(24'(st.ulf_cnt), 7); auto_req = 3'h1; end
      6'h2c: begin sel_bit = div_bit(24'(st.ulf_cnt), 10); auto_req = 3'h1; end
      6'h2d: begin sel_bit = div_bit(24'(st.ulf_cnt), 12); auto_req = 3'h1; end
      6'h2e: begin sel_bit = div_bit(24'(st.ulf_cnt), 20); auto_req = 3'h1; end
      6'h2f: begin sel_bit = div_bit(st.hf_cnt, 16); auto_req = 3'h4; end
      6'h30: begin sel_bit = div_bit(st.hf_cnt, 24); auto_req = 3'h4; end
      6'h31: begin sel_bit = div_bit(24'(st.lf_cnt), 20); auto_req = 3'h1; end
      6'h32: sel_bit = ticks.high_freq_rc_osc;
      6'h33: sel_bit = div_bit(st.hf_cnt, 3);
      6'h35: sel_bit = ticks.xt;
      6'h36: sel_bit = div_bit(24'(st.xt_cnt), 4);
      6'h37: sel_bit = div_bit(24'(st.lf_cnt), 5);
      6'h00: begin sel_bit = ticks.low_freq_rc_osc; auto_req = 3'h1; end
      // unmatched codes behave as the not-autoenabled low_freq_rc_osc
      default: sel_bit = ticks.low_freq_rc_osc;
    endcase
    next_st.clock_output_select  = sel_bit;
    next_st.auto_en = auto_req;

    // crystal slow detection: gap between xt ticks
    if (ticks.xt) begin
      next_st.gap_cnt = 16'h0000;
      next_st.xt_slow = 1'b0;
    end else if (st.gap_cnt >= 16'(XT_SLOW_GAP_CYC)) begin
      next_st.xt_slow = 1'b1;
    end else begin
      next_st.gap_cnt = st.gap_cnt + 16'h0001;
    end
    if (!st.xt_slow) begin
      next_st.fail_cnt = 21'h0;
      next_st.xt_fail  = 1'b0;
    end else if (st.fail_cnt >= 21'(XT_FAIL_CYC)) begin
      next_st.xt_fail = 1'b1;
    end else begin
      next_st.fail_cnt = st.fail_cnt + 21'h1;
    end

    // rtc oscillator: low_freq_rc_osc if asked, or xt failed with switch-over
    next_st.rtc_low_freq_rc_osc = st.osc_req || (st.switch_on_failure && st.xt_fail);

    // interrupt flags; a hardware or forced set wins over a clear
    hw_set = 4'h0;
    hw_set[`CGC_IRQ_ALARM]  = events.alarm;
    hw_set[`CGC_IRQ_XTFAIL] = (next_st.xt_fail && !st.xt_fail) || !st.pwr_done;
    hw_set[`CGC_IRQ_ACDONE] = events.autocal_done;
    hw_set[`CGC_IRQ_ACFAIL] = events.autocal_fail;
    next_st.pwr_done = 1'b1;
    if (wr_acc && paddr == `CGC_OFS_IRQ_STAT) next_st.irq_flag = pwdata[3:0];
    if (wr_acc && paddr == `CGC_OFS_IRQ_CLR) begin
      next_st.irq_flag = st.irq_flag & ~pwdata[3:0];
    end
    if (wr_acc && paddr == `CGC_OFS_IRQ_SET) begin
      next_st.irq_flag = next_st.irq_flag | pwdata[3:0];
    end
    next_st.irq_flag = next_st.irq_flag | hw_set;
    next_st.irq = |(next_st.irq_flag & next_st.irq_en);

    // automatic trimming; the measured correction is the target
    if (sec_tick && st.trim_st != TR_IDLE) next_st.sec_cnt = st.sec_cnt + 11'h001;
    case (st.trim_st)
      TR_IDLE: begin
        next_st.sec_cnt = 11'h000;
        if (st.trim_en) next_st.trim_st = TR_WARM;
      end
      TR_WARM: begin
        if (st.sec_cnt >= (st.warm_sel ? `CGC_WARM_LONG : `CGC_WARM_SHORT)) begin
          next_st.trim_st = TR_APPLY;
        end
      end
      TR_APPLY: begin
        next_st.trim_value = st.trim_target;
        next_st.sec_cnt    = 11'h000;
        next_st.trim_st    = TR_WAIT;
      end
      TR_WAIT: begin
        if (st.sec_cnt >= period_secs(st.trim_period)) next_st.trim_st = TR_APPLY;
      end
      default: next_st.trim_st = TR_IDLE;
    endcase
    if (!st.trim_en) next_st.trim_st = TR_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= '0;
      st.core_sel <= `CGC_CORE_RESET;
      st.trim_st  <= TR_IDLE;
    end else if (cken) begin
      st <= next_st;
    end
  end

  assign pready              = st.pready;
  assign prdata              = st.prdata;
  assign pslverr             = st.pslverr;
  assign clock_output_select              = st.clock_output_select;
  assign core_clk_en         = st.core_clk_en;
  assign flash_clk_en        = st.flash_clk_en;
  assign serial_clock_enable = st.uart_en;
  assign src_auto_enable     = st.auto_en;
  assign rtc_osc_in_use      = st.rtc_low_freq_rc_osc;
  assign trim_current_value  = st.trim_value;
  assign irq                 = st.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_div_write;
    cken && psel && penable && pready && pwrite && paddr == `CGC_OFS_DIV;
  endsequence

  a_key_guard: assert property (s_div_write ##0 (st.key != `CGC_KEY_VALUE) |=>
    $stable(st.core_sel) && $stable(st.flash_sel))
    else $error("divider changed without key");
  a_key_accept: assert property (s_div_write ##0 (st.key == `CGC_KEY_VALUE) |=>
    st.core_sel == $past(pwdata[2:0]))
    else $error("keyed divider write lost");
  a_irq_out: assert property (cken |=> irq == |(st.irq_flag & st.irq_en))
    else $error("irq output does not match flags");
  a_clr_flag: assert property (cken && psel && penable && pready && pwrite &&
    paddr == `CGC_OFS_IRQ_CLR && pwdata[0] && !events.autocal_fail |=> !st.irq_flag[0])
    else $error("clear did not clear flag");
  a_set_flag: assert property (cken && psel && penable && pready && pwrite &&
    paddr == `CGC_OFS_IRQ_SET && pwdata[3] |=> st.irq_flag[3])
    else $error("set did not set flag");
  a_osc_status: assert property (cken && st.osc_req |=> rtc_osc_in_use)
    else $error("rtc not on low_freq_rc_osc when requested");
  a_fos_switch: assert property (cken && st.switch_on_failure && st.xt_fail |=> rtc_osc_in_use)
    else $error("no switch on crystal failure");
  a_trim_off: assert property (!st.trim_en && cken |=> st.trim_st == TR_IDLE)
    else $error("trim runs while disabled");
  // a frozen enable would hold the pulse, so only judge freshly launched pulses
  a_core_pulse: assert property (core_clk_en && $past(cken) |->
    $past(st.core_cnt) >= $past(st.core_sel))
    else $error("core pulse early");
  a_flash_pulse: assert property (flash_clk_en && $past(cken) |->
    $past(st.flash_cnt) >= ($past(st.flash_sel) ? `CGC_FLASH_DIV_HI : `CGC_FLASH_DIV_LO))
    else $error("flash pulse early");
  a_ready_one: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");

  // output selection, one register stage behind the source
  a_clock_output_select_xt: assert property (cken && st.clock_output_select_sel == 6'h17 |=>
    clock_output_select == $past(ticks.xt))
    else $error("crystal code does not pass the crystal tick");
  a_clock_output_select_hf: assert property (cken && st.clock_output_select_sel == 6'h19 |=>
    clock_output_select == $past(ticks.high_freq_rc_osc))
    else $error("hf rc code does not pass the hf rc tick");
  a_clock_output_select_lf: assert property (cken && st.clock_output_select_sel == 6'h3f |=>
    clock_output_select == $past(ticks.low_freq_rc_osc) && src_auto_enable == 3'h0)
    else $error("undefined code does not fall back to lf rc");
  a_auto_none: assert property (cken && st.clock_output_select_sel == 6'h32 |=>
    src_auto_enable == 3'h0)
    else $error("not-autoenabled code requests a source");
  a_auto_xt: assert property (cken && st.clock_output_select_sel == 6'h03 |=>
    src_auto_enable == 3'h2)
    else $error("crystal divider does not request the crystal");

  sequence s_gate_write;
    cken && psel && penable && pready && pwrite && paddr == `CGC_OFS_SERGATE;
  endsequence

  a_uart_gate: assert property (s_gate_write |=>
    serial_clock_enable == $past(pwdata[0]))
    else $error("serial gate write lost");

  // read data is captured on the first access cycle
  sequence s_rd_status;
    cken && psel && penable && !pready && !pwrite && paddr == `CGC_OFS_STATUS;
  endsequence

  sequence s_rd_flags;
    cken && psel && penable && !pready && !pwrite && paddr == `CGC_OFS_IRQ_STAT;
  endsequence

  a_status_osc: assert property (s_rd_status |=>
    prdata[1] == (($past(xt_enabled) && $past(st.xt_slow)) || $past(st.osc_req)))
    else $error("not-running status wrong");
  a_status_mode: assert property (s_rd_status |=> prdata[0] == $past(st.rtc_low_freq_rc_osc))
    else $error("rtc oscillator status wrong");
  a_flags_read: assert property (s_rd_flags |=> prdata[3:0] == $past(st.irq_flag))
    else $error("flag readback wrong");
  a_fail_flag: assert property ($rose(st.xt_fail) |-> st.irq_flag[`CGC_IRQ_XTFAIL])
    else $error("crystal failure did not raise its flag");
  a_rtc_back: assert property (cken && !st.osc_req && !st.xt_fail |=>
    !rtc_osc_in_use)
    else $error("rtc did not return to the crystal");
  a_trim_apply: assert property (cken && st.trim_st == TR_APPLY |=>
    trim_current_value == $past(st.trim_target))
    else $error("trim target not applied");
  a_irq_gate: assert property (irq |-> |(st.irq_flag & st.irq_en))
    else $error("irq without an enabled flag");

endmodule : cgc_top
`default_nettype wire

// ---- tb/test_clock_generator_controls.sv ----
`include "cgc_map.svh"
`default_nettype none
module test_clock_generator_controls
  import cgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk;
  logic        presetn;
  logic        cken;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  cgc_ticks_s  ticks;
  cgc_events_s events;
  logic        xt_enabled;
  logic        xt_run;
  logic        clock_output_select;
  logic        core_clk_en;
  logic        flash_clk_en;
  logic        serial_clock_enable;
  logic [2:0]  src_auto_enable;
  logic        rtc_osc_in_use;
  logic [10:0] trim_current_value;
  logic        irq;
  int          err_total;
  int          check_count;

  // short fault-detect counts keep the crystal scenario brief
  cgc_top #(.XT_SLOW_GAP_CYC(20), .XT_FAIL_CYC(50)) dut (
    .pclk(pclk), .presetn(presetn), .cken(cken), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .ticks(ticks), .events(events), .xt_enabled(xt_enabled),
    .clock_output_select(clock_output_select), .core_clk_en(core_clk_en), .flash_clk_en(flash_clk_en),
    .serial_clock_enable(serial_clock_enable), .src_auto_enable(src_auto_enable),
    .rtc_osc_in_use(rtc_osc_in_use), .trim_current_value(trim_current_value), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // hf rc ticks every cycle so divider gaps read directly in cycles
  always @(posedge pclk) begin
    ticks <= {xt_run, 1'($urandom), 1'($urandom), 1'b1, 1'b0, 1'b0};
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // entered just after a rising edge; one idle edge follows the release
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      $display("CHECK FAILED pready expected 1 seen timeout");
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(what, r, exp);
  endtask : rd_chk

  task automatic gap(input logic flash, output int g);
    int n;
    n = 0;
    g = 0;
    while ((flash ? flash_clk_en : core_clk_en) !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    do begin
      @(posedge pclk);
      g++;
    end while ((flash ? flash_clk_en : core_clk_en) !== 1'b1 && g < 100);
  endtask : gap

  initial begin
    #1800000;
    err_total++;
    final_report();
  end

  initial begin
    logic [11:0] ra[10];
    logic [31:0] rv[10];
    logic [5:0]  code[12];
    logic [2:0]  aen[12];
    logic [31:0] r;
    logic        e;
    int          g;
    int          c;
    int          n;
    logic [3:0]  m;
    logic [3:0]  flags;
    logic [3:0]  en;
    logic [10:0] t;
    ra = '{`CGC_OFS_KEY, `CGC_OFS_DIV, `CGC_OFS_STATUS, `CGC_OFS_TRIM, `CGC_OFS_TRIMVAL,
           `CGC_OFS_GATESTAT, `CGC_OFS_SERGATE, `CGC_OFS_IRQ_EN, `CGC_OFS_IRQ_STAT,
           `CGC_OFS_CLOCK_OUTPUT_SELECT};
    // crystal-fail flag is up from power-up; code 0 auto-enables lf rc
    rv = '{32'h0, 32'h7, 32'h0, 32'h0, 32'h0, 32'h2, 32'h0, 32'h0, 32'h4, 32'h0};
    code = '{6'h00, 6'h03, 6'h17, 6'h1c, 6'h24, 6'h2b, 6'h2f, 6'h32, 6'h35, 6'h37,
             6'h39, 6'h3f};
    aen = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h1, 3'h1, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
    err_total = 0;
    check_count = 0;
    cken = 1'b1;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ticks = '0;
    events = '0;
    xt_enabled = 1'b0;
    xt_run = 1'b1;
    void'($urandom(9762));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      rd_chk("reset_value", ra[i], rv[i]);
    end
    wr(`CGC_OFS_DIV, 32'h0000_000b);
    rd_chk("div_locked", `CGC_OFS_DIV, 32'h7);
    gap(1'b0, g);
    check("core_gap_reset", g, 8);
    wr(`CGC_OFS_KEY, `CGC_KEY_VALUE);
    rd_chk("key", `CGC_OFS_KEY, 32'h47);
    wr(`CGC_OFS_DIV, 32'h0000_000b);
    rd_chk("div", `CGC_OFS_DIV, 32'hb);
    gap(1'b0, g);
    check("core_gap", g, 4);
    gap(1'b1, g);
    check("flash_gap45", g, 45);
    c = $urandom % 8;
    wr(`CGC_OFS_DIV, 32'(c));
    gap(1'b0, g);
    check("core_gap_rand", g, c + 1);
    gap(1'b1, g);
    check("flash_gap25", g, 25);
    wr(`CGC_OFS_SERGATE, 32'h1);
    check("serial_gate", serial_clock_enable, 1);
    rd_chk("serial_gate_reg", `CGC_OFS_SERGATE, 32'h1);
    apb(1'b0, 12'h0f0, 32'h0, r, e);
    check("unmapped_err", e, 1);
    check("unmapped_data", r, 0);
    for (int i = 0; i < 12; i++) begin
      wr(`CGC_OFS_CLOCK_OUTPUT_SELECT, 32'(code[i]));
      rd_chk("clock_output_select_sel", `CGC_OFS_CLOCK_OUTPUT_SELECT, 32'(code[i]));
      check("auto_enable", src_auto_enable, aen[i]);
      rd_chk("gate_status", `CGC_OFS_GATESTAT, {28'h0, aen[i], 1'b1});
    end
    flags = 4'h4;
    en = 4'h0;
    for (int i = 0; i < 8; i++) begin
      m = 4'($urandom);
      if (i % 2 == 0) begin
        en = m;
        wr(`CGC_OFS_IRQ_EN, 32'(m));
      end else begin
        flags = flags | m;
        wr(`CGC_OFS_IRQ_SET, 32'(m));
      end
      check("irq_after_set", irq, |(flags & en));
      m = 4'($urandom);
      flags = flags & ~m;
      wr(`CGC_OFS_IRQ_CLR, 32'(m));
      rd_chk("irq_status", `CGC_OFS_IRQ_STAT, 32'(flags));
      check("irq_after_clr", irq, |(flags & en));
    end
    wr(`CGC_OFS_IRQ_CLR, 32'hf);
    wr(`CGC_OFS_IRQ_EN, 32'h8);
    events <= '{alarm: 1'b1, autocal_done: 1'b0, autocal_fail: 1'b1};
    @(posedge pclk);
    events <= '0;
    @(posedge pclk);
    check("irq_event", irq, 1);
    rd_chk("irq_event_flags", `CGC_OFS_IRQ_STAT, 32'h9);
    wr(`CGC_OFS_OSCCTL, 32'h2);
    xt_enabled <= 1'b1;
    xt_run <= 1'b0;
    repeat (100) @(posedge pclk);
    check("rtc_on_low_freq_rc_osc", rtc_osc_in_use, 1);
    rd_chk("status_fail", `CGC_OFS_STATUS, 32'h3);
    rd_chk("xt_fail_flag", `CGC_OFS_IRQ_STAT, 32'hd);
    xt_run <= 1'b1;
    repeat (5) @(posedge pclk);
    check("rtc_back_xt", rtc_osc_in_use, 0);
    rd_chk("status_ok", `CGC_OFS_STATUS, 32'h0);
    wr(`CGC_OFS_OSCCTL, 32'h1);
    rd_chk("status_req_low_freq_rc_osc", `CGC_OFS_STATUS, 32'h3);
    wr(`CGC_OFS_OSCCTL, 32'h0);
    t = 11'($urandom) | 11'h001;
    check("trim_idle", trim_current_value, 0);
    wr(`CGC_OFS_TRIM, {13'h0, t, 8'h01});
    rd_chk("trim_ctrl", `CGC_OFS_TRIM, {13'h0, t, 8'h01});
    n = 0;
    while (trim_current_value !== t && n < 70000) begin
      @(posedge pclk);
      n++;
    end
    // warm-up of two second boundaries: more than one second, at most two
    check("warm_span", (n > 32000 && n < 65700), 1);
    check("trim_applied", trim_current_value, t);
    rd_chk("trim_readback", `CGC_OFS_TRIMVAL, 32'(t));
    final_report();
  end
endmodule : test_clock_generator_controls
`default_nettype wire
